// ### design/slew_pkg.sv
// Purpose: shared constants for the system clock slew and post-divider block
// Assumes: one 32-bit control/status word reached over Avalon-MM
// Notes:   step hold length is an implementation figure, kept small

package slew_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [3:0] ADDR_CLOCK_SLEW_CONTROL = 4'h0;
    localparam int ADDR_W = 4;

    // ****************************************************************
    // field positions of clock_slew_control
    // ****************************************************************
    localparam int POST_DIV_LSB = 16;
    localparam int POST_DIV_W = 4;
    localparam int STEP_LIMIT_LSB = 8;
    localparam int STEP_LIMIT_W = 3;
    localparam int UP_EN_BIT = 2;
    localparam int DOWN_EN_BIT = 1;
    localparam int ACTIVE_BIT = 0;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [3:0] POST_DIV_RST = 4'h0;
    localparam logic [2:0] STEP_LIMIT_RST = 3'h2;
    localparam logic UP_EN_RST = 1'b1;
    localparam logic DOWN_EN_RST = 1'b0;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_FREQ_HZ = 40000000;
    localparam int STEP_HOLD_NS = 400;
    localparam int STEP_HOLD_CYCLES_RAW =
        (STEP_HOLD_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
    localparam int STEP_HOLD_CYCLES = (STEP_HOLD_CYCLES_RAW < 1) ? 1 : STEP_HOLD_CYCLES_RAW;
    localparam logic [7:0] STEP_HOLD_LAST = 8'(STEP_HOLD_CYCLES - 1);

    // ****************************************************************
    // divider widths
    // ****************************************************************
    localparam int DIV_W = 8;
    localparam logic [7:0] DIV_ONE = 8'h01;

    typedef enum logic {
        SLEW_IDLE,
        SLEW_STEPPING
    } slew_state_t;

endpackage : slew_pkg

// ### design/system_clock_slew_divider.sv
// Purpose: steps the main system clock rate through power-of-two divisors during a
//          frequency change and applies a programmable post-divider afterwards
// Assumes: one clock sys_clk at 40 MHz, synchronous active-high reset srst,
//          change requests come from logic on the same clock
// Notes:   the divided clock is delivered as a one-cycle enable pulse
//
// Overview of operation
// - The final clock rate is the system clock divided by the post-divider code plus one.
// - With both slew enables cleared the post-divider is ignored and the divisor is one.
// - The step limit code n sets the largest slew divisor 2^n, with code 000 using none.
// - A downward change walks the slew divisors upward, 2 then 4 up to the limit.
// - An upward change is slewed only while the upward enable is set, which resets to one.
// - A downward change is slewed only while the downward enable is set, resetting to zero.
// - The read-only active bit is set while slewing and cleared once the final rate holds.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.

`timescale 1ns/100ps

module system_clock_slew_divider
    import slew_pkg::*;
(
    input wire logic sys_clk, // system clock, 40 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic [3:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall while not yet answered
    input wire logic freq_change_req, // one-cycle pulse: start a frequency change
    input wire logic freq_change_up, // direction of that change, 1 = higher rate
    output logic main_clk_en, // one-cycle enable at the divided rate
    output logic [7:0] active_divisor, // divisor now applied
    output logic slew_active // slewing in progress
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [7:0] pow2_div(input logic [2:0] exp);
        pow2_div = 8'h01 << exp;
    endfunction : pow2_div

    function automatic logic lane_on(input logic [3:0] be, input int bit_pos);
        lane_on = be[bit_pos / 8];
    endfunction : lane_on

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [3:0] system_clock_post_divider_ff;
    logic [2:0] slew_step_limit_ff;
    logic upward_slew_enable_ff;
    logic downward_slew_enable_ff;
    logic busy_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;

    slew_state_t state_ff;
    logic [2:0] step_exp_ff;
    logic [2:0] limit_ff;
    logic dir_up_ff;
    logic [7:0] hold_cnt_ff;
    logic [7:0] div_cnt_ff;
    logic [7:0] divisor_ff;
    logic clk_en_ff;

    logic access;
    logic reg_hit;
    logic wr_take;
    logic start_slew;
    logic step_done;
    logic last_step;
    logic [7:0] final_div;
    logic [7:0] nxt_divisor;
    logic [31:0] ctrl_word;

    // ****************************************************************
    // bus slave: one wait state on every access
    // ****************************************************************
    assign access = avs_read | avs_write;
    assign reg_hit = (avs_address == ADDR_CLOCK_SLEW_CONTROL);
    assign avs_waitrequest = access & ~ack_ff;
    assign wr_take = avs_write & ack_ff & reg_hit;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= access & ~ack_ff;
        end
    end

    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[POST_DIV_LSB +: POST_DIV_W] = system_clock_post_divider_ff;
        ctrl_word[STEP_LIMIT_LSB +: STEP_LIMIT_W] = slew_step_limit_ff;
        ctrl_word[UP_EN_BIT] = upward_slew_enable_ff;
        ctrl_word[DOWN_EN_BIT] = downward_slew_enable_ff;
        ctrl_word[ACTIVE_BIT] = busy_ff;
    end

    // read data captured in the wait cycle so it stands when waitrequest drops
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read & ~ack_ff) begin
            rdata_ff <= reg_hit ? ctrl_word : 32'h0000_0000;
        end
    end
    assign avs_readdata = rdata_ff;

    // ****************************************************************
    // control fields
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            system_clock_post_divider_ff <= POST_DIV_RST;
            slew_step_limit_ff <= STEP_LIMIT_RST;
            upward_slew_enable_ff <= UP_EN_RST;
            downward_slew_enable_ff <= DOWN_EN_RST;
        end else if (wr_take) begin
            if (lane_on(avs_byteenable, POST_DIV_LSB)) begin
                system_clock_post_divider_ff <= avs_writedata[POST_DIV_LSB +: POST_DIV_W];
            end
            if (lane_on(avs_byteenable, STEP_LIMIT_LSB)) begin
                slew_step_limit_ff <= avs_writedata[STEP_LIMIT_LSB +: STEP_LIMIT_W];
            end
            if (lane_on(avs_byteenable, UP_EN_BIT)) begin
                upward_slew_enable_ff <= avs_writedata[UP_EN_BIT];
                downward_slew_enable_ff <= avs_writedata[DOWN_EN_BIT];
            end
        end
    end

    // ****************************************************************
    // final divisor
    // ****************************************************************
    always_comb begin
        if (!upward_slew_enable_ff && !downward_slew_enable_ff) begin
            final_div = DIV_ONE;
        end else begin
            final_div = 8'({4'h0, system_clock_post_divider_ff}) + DIV_ONE;
        end
    end

    // ****************************************************************
    // slew sequencer
    // ****************************************************************
    // a request with the matching enable clear, or limit 000, switches at once
    assign start_slew = freq_change_req && (state_ff == SLEW_IDLE)
        && (slew_step_limit_ff != 3'h0)
        && (freq_change_up ? upward_slew_enable_ff : downward_slew_enable_ff);
    assign step_done = (hold_cnt_ff == STEP_HOLD_LAST);
    assign last_step = dir_up_ff ? (step_exp_ff == 3'h1) : (step_exp_ff == limit_ff);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_ff <= SLEW_IDLE;
            step_exp_ff <= 3'h0;
            limit_ff <= 3'h0;
            dir_up_ff <= 1'b0;
            hold_cnt_ff <= 8'h00;
        end else begin
            case (state_ff)
                SLEW_IDLE: begin
                    hold_cnt_ff <= 8'h00;
                    if (start_slew) begin
                        state_ff <= SLEW_STEPPING;
                        limit_ff <= slew_step_limit_ff;
                        dir_up_ff <= freq_change_up;
                        // upward starts at the largest divisor, downward at 2
                        step_exp_ff <= freq_change_up ? slew_step_limit_ff : 3'h1;
                    end
                end
                SLEW_STEPPING: begin
                    if (step_done) begin
                        hold_cnt_ff <= 8'h00;
                        if (last_step) begin
                            state_ff <= SLEW_IDLE;
                        end else if (dir_up_ff) begin
                            step_exp_ff <= step_exp_ff - 3'h1;
                        end else begin
                            step_exp_ff <= step_exp_ff + 3'h1;
                        end
                    end else begin
                        hold_cnt_ff <= hold_cnt_ff + 8'h01;
                    end
                end
                default: begin
                    state_ff <= SLEW_IDLE;
                end
            endcase
        end
    end

    // active rises with the request and falls as the final divisor takes over
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_ff <= 1'b0;
        end else if (start_slew) begin
            busy_ff <= 1'b1;
        end else if (state_ff == SLEW_STEPPING && step_done && last_step) begin
            busy_ff <= 1'b0;
        end
    end

    // ****************************************************************
    // clock divider
    // ****************************************************************
    always_comb begin
        if (start_slew) begin
            nxt_divisor = pow2_div(freq_change_up ? slew_step_limit_ff : 3'h1);
        end else if (state_ff == SLEW_STEPPING && !(step_done && last_step)) begin
            if (step_done) begin
                nxt_divisor = pow2_div(dir_up_ff ? step_exp_ff - 3'h1 : step_exp_ff + 3'h1);
            end else begin
                nxt_divisor = pow2_div(step_exp_ff);
            end
        end else begin
            nxt_divisor = final_div;
        end
    end

    // the counter restarts on a divisor change and an enable pulse is issued at once
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            divisor_ff <= DIV_ONE;
            div_cnt_ff <= 8'h00;
            clk_en_ff <= 1'b0;
        end else begin
            divisor_ff <= nxt_divisor;
            if (nxt_divisor != divisor_ff || div_cnt_ff >= divisor_ff - DIV_ONE) begin
                div_cnt_ff <= 8'h00;
                clk_en_ff <= 1'b1;
            end else begin
                div_cnt_ff <= div_cnt_ff + 8'h01;
                clk_en_ff <= 1'b0;
            end
        end
    end

    assign main_clk_en = clk_en_ff;
    assign active_divisor = divisor_ff;
    assign slew_active = busy_ff;

endmodule : system_clock_slew_divider

// ### verification/system_clock_slew_divider_props.sv
// Purpose: port-level checks of the slew divider
// Assumes: one clock domain, srst synchronous
// Notes:   16-cycle step hold is checked as 8 stable cycles
`timescale 1ns/100ps
module slew_divider_checker (
    input wire logic sys_clk, // clock
    input wire logic srst, // reset
    input wire logic freq_change_req, // change pulse
    input wire logic freq_change_up, // direction
    input wire logic main_clk_en, // divided enable
    input wire logic [7:0] active_divisor, // divisor in use
    input wire logic slew_active // busy
);
    // ****************************************************************
    // helper state
    // ****************************************************************
    logic up_ff;
    logic chg_ff;
    logic [7:0] gap_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    always_ff @(posedge sys_clk) begin
        if (freq_change_req && !slew_active) begin
            up_ff <= freq_change_up;
        end
    end
    // the enable restarts at once on a divisor change, yet the check skips until the next enable
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gap_ff <= 8'h01;
            chg_ff <= 1'b1;
        end else begin
            gap_ff <= main_clk_en ? 8'h01 : gap_ff + 8'h01;
            chg_ff <= $changed(active_divisor) || (chg_ff && !main_clk_en);
        end
    end
    a_slew_pow_two: assert property (slew_active |->
        active_divisor inside {8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80})
        else $error("slew divisor not a power of two");
    a_step_hold: assert property (slew_active && $changed(active_divisor)
        |=> $stable(active_divisor)[*8]) else $error("slew step held too briefly");
    a_start_on_req: assert property ($rose(slew_active) |-> $past(freq_change_req))
        else $error("busy rose without a request");
    a_down_first_two: assert property ($rose(slew_active) && !up_ff
        |-> active_divisor == 8'h02) else $error("downward slew not starting at 2");
    a_down_doubles: assert property (slew_active && $past(slew_active) && !up_ff
        && $changed(active_divisor) |-> active_divisor == ($past(active_divisor) << 1))
        else $error("downward step not doubling");
    a_up_halves: assert property (slew_active && $past(slew_active) && up_ff
        && $changed(active_divisor) |-> active_divisor == ($past(active_divisor) >> 1))
        else $error("upward step not halving");
    a_busy_bounded: assert property ($rose(slew_active) |-> ##[1:129] !slew_active)
        else $error("busy never cleared");
    a_clk_period: assert property (!chg_ff && $stable(active_divisor)
        |-> main_clk_en == (gap_ff == active_divisor)) else $error("enable period wrong");
    cover property ($rose(slew_active) && up_ff);
    cover property ($rose(slew_active) && !up_ff);
    cover property ($fell(slew_active));
endmodule : slew_divider_checker

bind system_clock_slew_divider slew_divider_checker slew_divider_checker_i (
    .sys_clk(sys_clk), .srst(srst), .freq_change_req(freq_change_req),
    .freq_change_up(freq_change_up), .main_clk_en(main_clk_en),
    .active_divisor(active_divisor), .slew_active(slew_active));

// ### verification/system_clock_slew_divider_tb.sv
// Purpose: self-checking bench for the slew divider
// Assumes: one wait state per bus access, 16-cycle slew steps
// Notes:   divisor and busy are compared every cycle of a slew
`timescale 1ns/100ps
module system_clock_slew_divider_tb import slew_pkg::*;;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic freq_change_req = 1'b0;
    logic freq_change_up = 1'b0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic main_clk_en;
    logic [7:0] active_divisor;
    logic slew_active;
    logic [31:0] rd;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    system_clock_slew_divider system_clock_slew_divider_i (.sys_clk(sys_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .freq_change_req(freq_change_req), .freq_change_up(freq_change_up),
        .main_clk_en(main_clk_en), .active_divisor(active_divisor), .slew_active(slew_active));
    // ****************************************************************
    // clock, watchdog and shared tasks
    // ****************************************************************
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_out
    // the request is held until waitrequest is seen low, whatever the latency
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= we;
        avs_read <= !we;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic pulse(input logic up);
        @(posedge sys_clk);
        freq_change_req <= 1'b1;
        freq_change_up <= up;
        @(posedge sys_clk);
        freq_change_req <= 1'b0;
    endtask : pulse
    // n steps of slewing expected, then the final divisor fin
    task automatic slew(input logic up, input int n, input logic [7:0] fin);
        int i;
        int h;
        logic b;
        logic [7:0] e;
        h = STEP_HOLD_CYCLES;
        pulse(up);
        for (i = 0; i < h * n + 4; i++) begin
            @(negedge sys_clk);
            b = (i < h * n);
            e = !b ? fin : up ? 8'(1 << (n - i / h)) : 8'(2 << (i / h));
            cmp_out(8'(slew_active), 8'(b));
            cmp_out(active_divisor, e);
        end
    endtask : slew
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        bus(1'b0, ADDR_CLOCK_SLEW_CONTROL, 32'h0);
        cmp_word(rd, 32'h0000_0204);
        bus(1'b0, 4'h4, 32'h0);
        cmp_word(rd, 32'h0);
        cmp_out(active_divisor, 8'h01);
        $display("test reset done");
    endtask : t_reset
    task automatic t_post;
        int n;
        bus(1'b1, ADDR_CLOCK_SLEW_CONTROL, 32'h000f_0204);
        bus(1'b0, ADDR_CLOCK_SLEW_CONTROL, 32'h0);
        cmp_word(rd, 32'h000f_0204);
        cmp_out(active_divisor, 8'h10);
        // sixteen-cycle period, so any 64 cycles hold exactly four enables
        n = 0;
        repeat (64) begin
            @(negedge sys_clk);
            n += int'(main_clk_en);
        end
        cmp_out(8'(n), 8'h04);
        bus(1'b1, ADDR_CLOCK_SLEW_CONTROL, 32'h000f_0201);
        bus(1'b0, ADDR_CLOCK_SLEW_CONTROL, 32'h0);
        cmp_word(rd, 32'h000f_0200);
        cmp_out(active_divisor, 8'h01);
        // only the post-divider lane is enabled, the other fields keep their value
        avs_byteenable <= 4'h4;
        bus(1'b1, ADDR_CLOCK_SLEW_CONTROL, 32'h0007_0707);
        avs_byteenable <= 4'hf;
        bus(1'b0, ADDR_CLOCK_SLEW_CONTROL, 32'h0);
        cmp_word(rd, 32'h0007_0200);
        cmp_out(active_divisor, 8'h01);
        slew(1'b1, 0, 8'h01);
        $display("test post divider done");
    endtask : t_post
    task automatic t_up;
        bus(1'b1, ADDR_CLOCK_SLEW_CONTROL, 32'h0003_0304);
        slew(1'b1, 3, 8'h04);
        slew(1'b0, 0, 8'h04);
        $display("test upward done");
    endtask : t_up
    task automatic t_down;
        bus(1'b1, ADDR_CLOCK_SLEW_CONTROL, 32'h0000_0702);
        slew(1'b0, 7, 8'h01);
        bus(1'b1, ADDR_CLOCK_SLEW_CONTROL, 32'h0000_0006);
        slew(1'b1, 0, 8'h01);
        $display("test downward done");
    endtask : t_down
    task automatic t_busy;
        bus(1'b1, ADDR_CLOCK_SLEW_CONTROL, 32'h0000_0104);
        pulse(1'b1);
        bus(1'b0, ADDR_CLOCK_SLEW_CONTROL, 32'h0);
        cmp_word(rd, 32'h0000_0105);
        repeat (20) @(negedge sys_clk);
        bus(1'b0, ADDR_CLOCK_SLEW_CONTROL, 32'h0);
        cmp_word(rd, 32'h0000_0104);
        $display("test status bit done");
    endtask : t_busy
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_post();
        t_up();
        t_down();
        t_busy();
        end_of_test();
    end
endmodule : system_clock_slew_divider_tb
